// [logic/fie_params.svh]
/*
 constants for the filtered input edge block.
 assumes inclusion by the block and its bench only.
*/
`ifndef FIE_PARAMS_SVH
`define FIE_PARAMS_SVH
`define FIE_CLK_MHZ       50
`define FIE_NCH           4
`define FIE_REC_DIAG4     8'h00
`define FIE_REC_DIAG      8'h01
`define FIE_REC_EVENT     8'h02
`define FIE_REC_EDGE      8'h80
`define FIE_DIAG_ON       8'h40
`define FIE_DIAG_LEN      5'h14
`define FIE_DIAG4_LEN     5'h04
`define FIE_EVENT_LEN     5'h04
`define FIE_EDGE_LEN      5'h02
`define FIE_RST_DELAY     8'h02
`define FIE_MODINFO       8'h1f
`define FIE_CHKIND        8'h70
`define FIE_DIAGBITS      8'h00
`define FIE_CHCOUNT       8'h04
`define FIE_D1_CODE       8'h00
`define FIE_D3_CODE       8'h02
`define FIE_D10_CODE      8'h04
`define FIE_D86_CODE      8'h07
`define FIE_D342_CODE     8'h09
`define FIE_D2731_CODE    8'h0c
`define FIE_D1_US         12'd1
`define FIE_D3_US         12'd3
`define FIE_D10_US        12'd10
`define FIE_D86_US        12'd86
`define FIE_D342_US       12'd342
`define FIE_D2731_US      12'd2731
`define FIE_BIT_MODFAIL   0
`define FIE_BIT_EXTERR    2
`define FIE_BIT_CHANNEL_FAULT_FLAGS     3
`define FIE_BIT_OVFL      3
`define FIE_BIT_LOST      6
`define FIE_IDX_ERRA      5'h00
`define FIE_IDX_MODINFO   5'h01
`define FIE_IDX_ERRD      5'h03
`define FIE_IDX_CHKIND    5'h04
`define FIE_IDX_DIAGBITS  5'h05
`define FIE_IDX_CHCOUNT   5'h06
`define FIE_IDX_CHANNEL_FAULT_FLAGS     5'h07
`define FIE_IDX_STAMP     5'h10
`endif

// [logic/fie_pkg.sv]
/*
 types for the filtered input edge block.
 assumes nothing of its surroundings.
*/
package fie_pkg;
    typedef logic [7:0]  fie_byte_t;
    typedef logic [11:0] fie_us_t;
    typedef logic [4:0]  fie_idx_t;
endpackage : fie_pkg

// [logic/fie_input_irq.sv]
/*
 four channel filtered input with edge events and diagnostics.
 assumes inputChannel comes from pins, all other inputs from logic on
 mclk; record accesses are single cycle strobes from the coupler side.
*/
// Function
// - diag enable byte 00h off, 40h on
// - delay byte picks filter time per channel
// - rising edge enable bits 0 to 3
// - falling edge enable bits per channel
// - edges give process event, losses give diag
// - event delivered as emergency or diag telegram
// - source byte marks channels with edges
// - snapshot byte holds filtered levels at event
// - free running 32 bit microsecond ticker
// - event stamp is ticker low 16 bits
// - incoming and going diag pulses automatically
// - channel events inside diag window dropped
// - fault indicator on during diag window
// - diag record 01h, first four as 00h
// - summary byte module, external, channel error
// - constant descriptor bytes in diag record
// - extended byte overflow bit 3, lost bit 6
// - channel fault bit n on lost edge
`timescale 1ns/10ps
`include "fie_params.svh"
module fie_input_irq #(
    parameter int CYC_PER_US = `FIE_CLK_MHZ
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic         clkEn,
    // pins
    input  wire logic [3:0]   inputChannel,
    // error sources and link type
    input  wire logic         moduleFailure,
    input  wire logic         externalError,
    input  wire logic         linkIsCanopen,
    // record access
    input  wire logic         recWrEn,
    input  wire logic         recRdEn,
    input  wire logic [7:0]   recordSetNumber,
    input  wire logic [4:0]   recByteIdx,
    input  wire logic [7:0]   recWrData,
    output logic [7:0]        recRdData,
    output logic              recRdValid,
    // interrupts and status
    input  wire logic         procIrqAck,
    input  wire logic         diagAck,
    output logic              procIrqEmergency,
    output logic              procIrqDiagTelegram,
    output logic              diagIrqIncoming,
    output logic              diagIrqGoing,
    output logic              moduleFaultIndicator,
    output logic [3:0]        inputState
);

    function automatic fie_pkg::fie_us_t delayUs(input fie_pkg::fie_byte_t code);
        unique case (code)
            `FIE_D1_CODE:    delayUs = `FIE_D1_US;
            `FIE_D3_CODE:    delayUs = `FIE_D3_US;
            `FIE_D10_CODE:   delayUs = `FIE_D10_US;
            `FIE_D86_CODE:   delayUs = `FIE_D86_US;
            `FIE_D342_CODE:  delayUs = `FIE_D342_US;
            `FIE_D2731_CODE: delayUs = `FIE_D2731_US;
            // illegal codes fall back to the reset filter time
            default:         delayUs = `FIE_D3_US;
        endcase
    endfunction : delayUs

    logic [3:0]          sync1_q, sync2_q, sync3_q, rawLvl_q;
    logic [3:0]          filt_q;
    fie_pkg::fie_us_t    fcnt_q [4];
    fie_pkg::fie_byte_t  delay_q [4];
    fie_pkg::fie_byte_t  diagEn_q, riseEn_q, fallEn_q;
    logic [31:0]         usCount_q, diagStamp_q;
    logic [15:0]         eventStamp_q;
    logic [7:0]          usPre_q;
    logic [3:0]          eventSrc_q, eventSnap_q, channel_fault_flags_q;
    logic                procPend_q, procIrq_q, lost_q, ovfl_q;
    logic                mfi_q, inc_q, going_q, rdValid_q;
    fie_pkg::fie_byte_t  rdData_q;

    // ticker prescale from the system clock
    wire usTick = (usPre_q == 8'(CYC_PER_US - 1));

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            usPre_q   <= 8'h00;
            usCount_q <= 32'h0000_0000;
        end else if (clkEn) begin
            usPre_q <= usTick ? 8'h00 : usPre_q + 8'h01;
            if (usTick) begin
                usCount_q <= usCount_q + 32'h0000_0001;
            end
        end
    end

    // level is taken once stages two and three agree
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sync1_q  <= 4'h0;
            sync2_q  <= 4'h0;
            sync3_q  <= 4'h0;
            rawLvl_q <= 4'h0;
        end else if (clkEn) begin
            sync1_q  <= inputChannel;
            sync2_q  <= sync1_q;
            sync3_q  <= sync2_q;
            rawLvl_q <= (sync2_q & sync3_q) | (rawLvl_q & (sync2_q ^ sync3_q));
        end
    end

    logic [3:0] filtD;
    logic [3:0] fdone;
    genvar g;
    for (g = 0; g < `FIE_NCH; g++) begin : gFilt
        assign fdone[g] = (fcnt_q[g] >= delayUs(delay_q[g]));
        assign filtD[g] = (rawLvl_q[g] != filt_q[g]) && fdone[g] ? rawLvl_q[g] : filt_q[g];
        // count in whole microseconds; grain is one tick
        always_ff @(posedge mclk) begin
            if (!resetn) begin
                fcnt_q[g] <= 12'h000;
                filt_q[g] <= 1'b0;
            end else if (clkEn) begin
                filt_q[g] <= filtD[g];
                if (rawLvl_q[g] == filt_q[g] || fdone[g]) begin
                    fcnt_q[g] <= 12'h000;
                end else if (usTick) begin
                    fcnt_q[g] <= fcnt_q[g] + 12'h001;
                end
            end
        end
    end

    // edge detection on the filtered level
    wire [3:0] rise   = filtD & ~filt_q & riseEn_q[3:0];
    wire [3:0] fall   = ~filtD & filt_q & fallEn_q[3:0];
    wire [3:0] edges  = rise | fall;
    wire       anyEdg = |edges;
    wire       pendEf = procPend_q & ~procIrqAck;
    wire       take   = anyEdg & ~mfi_q & ~pendEf;
    wire       loseEv = anyEdg & ~mfi_q & pendEf;
    wire       dropEv = anyEdg & mfi_q;
    wire       diagOn = (diagEn_q == `FIE_DIAG_ON);
    wire       cause  = moduleFailure | externalError | (|channel_fault_flags_q) | ovfl_q | lost_q;
    wire       diagAct = diagOn & cause;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            procPend_q   <= 1'b0;
            procIrq_q    <= 1'b0;
            eventSrc_q   <= 4'h0;
            eventSnap_q  <= 4'h0;
            eventStamp_q <= 16'h0000;
        end else if (clkEn) begin
            procIrq_q  <= take;
            procPend_q <= take | pendEf;
            if (take) begin
                eventSrc_q   <= edges;
                eventSnap_q  <= filtD;
                eventStamp_q <= usCount_q[15:0];
            end
        end
    end

    // set wins over the acknowledge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            channel_fault_flags_q <= 4'h0;
            lost_q  <= 1'b0;
            ovfl_q  <= 1'b0;
        end else if (clkEn) begin
            channel_fault_flags_q <= (diagAck ? 4'h0 : channel_fault_flags_q) | (loseEv ? edges : 4'h0);
            lost_q  <= (lost_q & ~diagAck) | loseEv;
            ovfl_q  <= (ovfl_q & ~diagAck) | dropEv;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mfi_q       <= 1'b0;
            inc_q       <= 1'b0;
            going_q     <= 1'b0;
            diagStamp_q <= 32'h0000_0000;
        end else if (clkEn) begin
            mfi_q   <= diagAct;
            inc_q   <= diagAct & ~mfi_q;
            going_q <= ~diagAct & mfi_q;
            if (diagAct & ~mfi_q) begin
                diagStamp_q <= usCount_q;
            end
        end
    end

    // parameter writes; stop-state discipline is the coupler's job
    wire wrDiag  = recWrEn && recordSetNumber == `FIE_REC_DIAG4 && recByteIdx == 5'h00;
    wire wrDly   = recWrEn && recordSetNumber == `FIE_REC_DIAG && recByteIdx < 5'h04;
    wire wrEdge  = recWrEn && recordSetNumber == `FIE_REC_EDGE;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            diagEn_q <= 8'h00;
            riseEn_q <= 8'h00;
            fallEn_q <= 8'h00;
            for (int i = 0; i < `FIE_NCH; i++) begin
                delay_q[i] <= `FIE_RST_DELAY;
            end
        end else if (clkEn) begin
            if (wrDiag) begin
                diagEn_q <= recWrData;
            end
            if (wrDly) begin
                delay_q[recByteIdx[1:0]] <= recWrData;
            end
            if (wrEdge && recByteIdx == 5'h00) begin
                riseEn_q <= {4'h0, recWrData[3:0]};
            end
            if (wrEdge && recByteIdx == 5'h01) begin
                fallEn_q <= {4'h0, recWrData[3:0]};
            end
        end
    end

    // diagnostic record bytes
    wire [7:0] errA = {4'h0, |channel_fault_flags_q, externalError, 1'b0, moduleFailure};
    wire [7:0] errD = {1'b0, lost_q, 2'b00, ovfl_q, 3'b000};
    logic [7:0] diagByte;
    always_comb begin
        diagByte = 8'h00;
        unique case (recByteIdx)
            `FIE_IDX_ERRA:     diagByte = errA;
            `FIE_IDX_MODINFO:  diagByte = `FIE_MODINFO;
            `FIE_IDX_ERRD:     diagByte = errD;
            `FIE_IDX_CHKIND:   diagByte = `FIE_CHKIND;
            `FIE_IDX_DIAGBITS: diagByte = `FIE_DIAGBITS;
            `FIE_IDX_CHCOUNT:  diagByte = `FIE_CHCOUNT;
            `FIE_IDX_CHANNEL_FAULT_FLAGS:    diagByte = {4'h0, channel_fault_flags_q};
            `FIE_IDX_STAMP:          diagByte = diagStamp_q[7:0];
            `FIE_IDX_STAMP + 5'h01:  diagByte = diagStamp_q[15:8];
            `FIE_IDX_STAMP + 5'h02:  diagByte = diagStamp_q[23:16];
            `FIE_IDX_STAMP + 5'h03:  diagByte = diagStamp_q[31:24];
            default:           diagByte = 8'h00;
        endcase
    end

    logic [7:0] evByte;
    always_comb begin
        evByte = 8'h00;
        unique case (recByteIdx[1:0])
            2'h0: evByte = {4'h0, eventSrc_q};
            2'h1: evByte = {4'h0, eventSnap_q};
            2'h2: evByte = eventStamp_q[7:0];
            2'h3: evByte = eventStamp_q[15:8];
        endcase
    end

    wire [7:0] rdByte =
        (recordSetNumber == `FIE_REC_DIAG && recByteIdx < `FIE_DIAG_LEN) ? diagByte :
        (recordSetNumber == `FIE_REC_DIAG4 && recByteIdx < `FIE_DIAG4_LEN) ? diagByte :
        (recordSetNumber == `FIE_REC_EVENT && recByteIdx < `FIE_EVENT_LEN) ? evByte :
        (recordSetNumber == `FIE_REC_EDGE && recByteIdx == 5'h00) ? riseEn_q :
        (recordSetNumber == `FIE_REC_EDGE && recByteIdx == 5'h01) ? fallEn_q : 8'h00;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdData_q  <= 8'h00;
            rdValid_q <= 1'b0;
        end else if (clkEn) begin
            rdValid_q <= recRdEn;
            if (recRdEn) begin
                rdData_q <= rdByte;
            end
        end
    end

    // telegram choice is made once per event
    logic emerg_q, dtel_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            emerg_q <= 1'b0;
            dtel_q  <= 1'b0;
        end else if (clkEn) begin
            emerg_q <= take & linkIsCanopen;
            dtel_q  <= take & ~linkIsCanopen;
        end
    end

    assign recRdData            = rdData_q;
    assign recRdValid           = rdValid_q;
    assign procIrqEmergency     = emerg_q;
    assign procIrqDiagTelegram  = dtel_q;
    assign diagIrqIncoming      = inc_q;
    assign diagIrqGoing         = going_q;
    assign moduleFaultIndicator = mfi_q;
    assign inputState           = filt_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_diag_off_dark: assert property (clkEn && !diagOn |=> !mfi_q)
        else $error("fault indicator on while diag disabled");
    // only the bits that moved must match the raw level; others may still count
    a_filter_level: assert property ($changed(filt_q) |->
        (($past(filt_q) ^ filt_q) & ($past(rawLvl_q) ^ filt_q)) == 4'h0)
        else $error("filter changed to a level not present");
    a_ticker_step: assert property (clkEn && usTick |=> usCount_q == $past(usCount_q) + 32'h1)
        else $error("ticker did not advance");
    a_snap_levels: assert property (clkEn && take |=> eventSnap_q == $past(filtD))
        else $error("snapshot differs from filtered levels");
    a_stamp_low: assert property (clkEn && take |=> eventStamp_q == $past(usCount_q[15:0]))
        else $error("event stamp not ticker low half");
    a_source_bits: assert property (procIrq_q |-> eventSrc_q != 4'h0)
        else $error("event raised with empty source");
    a_window_rise: assert property ($rose(mfi_q) |-> inc_q && diagStamp_q == $past(usCount_q))
        else $error("window opened without incoming pulse");
    a_window_fall: assert property ($fell(mfi_q) |-> going_q)
        else $error("window closed without going pulse");
    a_window_drop: assert property (clkEn && mfi_q |=> !procIrq_q)
        else $error("event raised inside diag window");
    a_lost_flag: assert property (clkEn && loseEv |=> (channel_fault_flags_q & $past(edges)) == $past(edges) && lost_q)
        else $error("lost edge not flagged");
    a_event_pulse: assert property (clkEn && take |=> procIrq_q && (emerg_q ^ dtel_q))
        else $error("accepted event gave no single telegram pulse");
    a_pend_hold: assert property (clkEn && procPend_q && !procIrqAck |=> !procIrq_q)
        else $error("event accepted while one is pending");
    a_edge_rsvd: assert property (riseEn_q[7:4] == 4'h0 && fallEn_q[7:4] == 4'h0)
        else $error("reserved edge enable bits set");
    a_drop_ovfl: assert property (clkEn && dropEv |=> ovfl_q)
        else $error("dropped edge did not flag overflow");
    a_diag_open: assert property (clkEn && diagAct && !mfi_q |=> inc_q && mfi_q)
        else $error("diag cause gave no incoming pulse");
    a_read_answer: assert property (clkEn && recRdEn |=> recRdValid)
        else $error("read strobe gave no valid pulse");

    c_proc_event: cover property (procIrq_q);
    c_diag_in: cover property (inc_q);
    c_diag_out: cover property (going_q);
    c_lost_edge: cover property (loseEv);
    c_drop_edge: cover property (dropEv);

endmodule : fie_input_irq

// [test/fie_coupler_model.sv]
/*
 coupler side model: record accesses and acknowledges on mclk.
 assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/10ps
module fie_coupler_model (
    // clock
    input  wire logic       mclk,
    // record access
    output logic            recWrEn,
    output logic            recRdEn,
    output logic [7:0]      recordSetNumber,
    output logic [4:0]      recByteIdx,
    output logic [7:0]      recWrData,
    // acknowledges
    output logic            procIrqAck,
    output logic            diagAck
);
    logic stopState;
    initial begin
        {recWrEn, recRdEn, procIrqAck, diagAck} = 4'h0;
        {recordSetNumber, recByteIdx, recWrData} = 21'h0;
        stopState = 1'b1;
    end
    // one strobe cycle; lines scrambled after so stale values never look live
    task automatic access(input logic wr, input logic [7:0] set, input logic [4:0] idx,
                          input logic [7:0] data);
        @(posedge mclk);
        #1;
        if (wr && set == 8'h00 && !stopState) begin
            return;
        end
        {recWrEn, recRdEn} = {wr, !wr};
        {recordSetNumber, recByteIdx, recWrData} = {set, idx, data};
        @(posedge mclk);
        #1;
        {recWrEn, recRdEn} = 2'b00;
        {recordSetNumber, recByteIdx, recWrData} = ~{set, idx, data};
    endtask : access
    task automatic ack(input logic p, input logic d);
        @(posedge mclk);
        #1;
        {procIrqAck, diagAck} = {p, d};
        @(posedge mclk);
        #1;
        {procIrqAck, diagAck} = 2'b00;
    endtask : ack
endmodule : fie_coupler_model

// [test/tb.sv]
/*
 self-checking bench for the filtered input edge block.
 assumes the coupler model for record traffic and a shortened microsecond.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
    logic       mclk, resetn, clkEn, moduleFailure, externalError, linkIsCanopen;
    logic [3:0] inputChannel;
    logic       recWrEn, recRdEn, procIrqAck, diagAck, recRdValid;
    logic [7:0] recordSetNumber, recWrData, recRdData;
    logic [4:0] recByteIdx;
    logic       procIrqEmergency, procIrqDiagTelegram, diagIrqIncoming, diagIrqGoing;
    logic       moduleFaultIndicator, got;
    logic [3:0] inputState;
    logic [7:0] expQ[$];
    logic [7:0] riseEn;
    int         failures, n_tests, cnt;
    wire  [3:0] pulses = {diagIrqGoing, diagIrqIncoming, procIrqDiagTelegram,
                          procIrqEmergency};
    // two cycles per microsecond keeps the filter counts short
    fie_input_irq #(.CYC_PER_US(2)) dut_u (.mclk(mclk), .resetn(resetn), .clkEn(clkEn),
        .inputChannel(inputChannel), .moduleFailure(moduleFailure),
        .externalError(externalError), .linkIsCanopen(linkIsCanopen), .recWrEn(recWrEn),
        .recRdEn(recRdEn), .recordSetNumber(recordSetNumber), .recByteIdx(recByteIdx),
        .recWrData(recWrData), .recRdData(recRdData), .recRdValid(recRdValid),
        .procIrqAck(procIrqAck), .diagAck(diagAck), .procIrqEmergency(procIrqEmergency),
        .procIrqDiagTelegram(procIrqDiagTelegram), .diagIrqIncoming(diagIrqIncoming),
        .diagIrqGoing(diagIrqGoing), .moduleFaultIndicator(moduleFaultIndicator),
        .inputState(inputState));
    fie_coupler_model cpl_u (.mclk(mclk), .recWrEn(recWrEn), .recRdEn(recRdEn),
        .recordSetNumber(recordSetNumber), .recByteIdx(recByteIdx), .recWrData(recWrData),
        .procIrqAck(procIrqAck), .diagAck(diagAck));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic wrap_up();
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic rd(input logic [7:0] set, input logic [4:0] idx, input logic [7:0] e);
        expQ.push_back(e);
        cpl_u.access(1'b0, set, idx, 8'h00);
    endtask : rd
    task automatic drv(input logic [6:0] v);
        @(posedge mclk);
        #1;
        {linkIsCanopen, externalError, moduleFailure, inputChannel} = v;
    endtask : drv
    task automatic wait_sig(input int k, input int lim);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge mclk);
            #2;
            got = pulses[k];
        end
    endtask : wait_sig
    // read results come one cycle after the strobe, oldest note first
    always @(posedge mclk) begin
        if (recRdValid === 1'b1) begin
            if (expQ.size() == 0) begin
                `CHK(1'b1, 1'b0)
            end else begin
                `CHK(recRdData, expQ.pop_front())
            end
        end
    end
    initial begin
        #(20 * 20000);
        failures++;
        wrap_up();
    end
    initial begin
        {resetn, clkEn, moduleFailure, externalError, linkIsCanopen} = 5'b01000;
        inputChannel = 4'h0;
        void'($urandom(32'h6c00));
        repeat (10) @(posedge mclk);
        #1;
        resetn = 1'b1;
        rd(8'h80, 5'h00, 8'h00);
        rd(8'h80, 5'h01, 8'h00);
        rd(8'h01, 5'h01, 8'h1f);
        rd(8'h01, 5'h04, 8'h70);
        rd(8'h01, 5'h05, 8'h00);
        rd(8'h01, 5'h06, 8'h04);
        rd(8'h00, 5'h01, 8'h1f);
        rd(8'h05, 5'h00, 8'h00);
        // glitch shorter than 10 us is swallowed, a held level passes late
        cpl_u.access(1'b1, 8'h01, 5'h03, 8'h04);
        drv(7'h08);
        repeat (2 + $urandom % 8) @(posedge mclk);
        drv(7'h00);
        repeat (40) @(posedge mclk);
        `CHK(inputState[3], 1'b0)
        drv(7'h08);
        cnt = 0;
        while (inputState[3] !== 1'b1 && cnt < 80) begin
            @(posedge mclk);
            cnt++;
        end
        `CHK(cnt >= 20 && cnt < 80, 1'b1)
        drv(7'h00);
        repeat (40) @(posedge mclk);
        // longer code on the same channel: 86 us is 172 cycles plus sync
        cpl_u.access(1'b1, 8'h01, 5'h03, 8'h07);
        drv(7'h08);
        cnt = 0;
        while (inputState[3] !== 1'b1 && cnt < 400) begin
            @(posedge mclk);
            cnt++;
        end
        `CHK(cnt >= 172 && cnt < 190, 1'b1)
        drv(7'h00);
        repeat (200) @(posedge mclk);
        for (int c = 0; c < 3; c++) cpl_u.access(1'b1, 8'h01, c[4:0], 8'h00);
        riseEn = {4'($urandom % 16), 4'hf};
        cpl_u.access(1'b1, 8'h80, 5'h00, riseEn);
        cpl_u.access(1'b1, 8'h80, 5'h01, 8'hff);
        rd(8'h80, 5'h00, 8'h0f);
        rd(8'h80, 5'h01, 8'h0f);
        drv(7'h41);
        wait_sig(0, 60);
        `CHK(got, 1'b1)
        `CHK(procIrqDiagTelegram, 1'b0)
        rd(8'h02, 5'h00, 8'h01);
        rd(8'h02, 5'h01, 8'h01);
        cpl_u.ack(1'b1, 1'b0);
        drv(7'h00);
        wait_sig(1, 60);
        `CHK(got, 1'b1)
        rd(8'h02, 5'h01, 8'h00);
        cpl_u.ack(1'b1, 1'b0);
        cpl_u.access(1'b1, 8'h00, 5'h00, 8'h40);
        drv(7'h02);
        wait_sig(1, 60);
        `CHK(got, 1'b1)
        rd(8'h02, 5'h00, 8'h02);
        // second edge while the first is unacknowledged gets lost
        drv(7'h00);
        wait_sig(2, 60);
        `CHK(got, 1'b1)
        `CHK(moduleFaultIndicator, 1'b1)
        rd(8'h01, 5'h07, 8'h02);
        rd(8'h01, 5'h03, 8'h40);
        rd(8'h00, 5'h00, 8'h08);
        drv(7'h04);
        wait_sig(1, 60);
        `CHK(got, 1'b0)
        rd(8'h01, 5'h03, 8'h48);
        cpl_u.ack(1'b1, 1'b1);
        wait_sig(3, 20);
        `CHK(got, 1'b1)
        `CHK(moduleFaultIndicator, 1'b0)
        drv(7'h14);
        wait_sig(2, 20);
        `CHK(got, 1'b1)
        rd(8'h01, 5'h00, 8'h01);
        drv(7'h34);
        rd(8'h01, 5'h00, 8'h05);
        drv(7'h04);
        wait_sig(3, 20);
        `CHK(got, 1'b1)
        cpl_u.access(1'b1, 8'h00, 5'h00, 8'h00);
        drv(7'h14);
        wait_sig(2, 40);
        `CHK(got, 1'b0)
        `CHK(moduleFaultIndicator, 1'b0)
        // frozen clock enable holds the pin change off until it returns
        @(posedge mclk);
        #1;
        clkEn = 1'b0;
        drv(7'h00);
        repeat (20) @(posedge mclk);
        #1;
        `CHK(inputState, 4'h4)
        clkEn = 1'b1;
        wait_sig(1, 40);
        `CHK(got, 1'b1)
        drv(7'h04);
        repeat (5) @(posedge mclk);
        `CHK(expQ.size(), 0)
        wrap_up();
    end
endmodule : tb
